// ---- mtde_top.sv ----
// Purpose: transmit MAC DMA error signalling with AXI4-Lite registers
// Assumes: 250 MHz clock, all inputs synchronous to it
// Notes: error pulses also land in sticky status for a level interrupt
//
// Contract
// RULE1 - Any error while the transmit DMA runs raises the transmit DMA error interrupt.
// RULE2 - That interrupt is a single-cycle pulse needing no clearing.
// RULE3 - Software reads the error status after the interrupt to learn the cause.
// RULE4 - Software fixes the descriptor before asking for retransmission.
// RULE5 - Access to a buffer the CPU has not acquired gives a one-cycle buffer RAM error pulse.
// RULE6 - Software should keep store_forward_select (bit 29 of tx_mode_register) at 1.
// RULE7 - Frames longer than 1518 bytes are unsupported and count as a bad byte count.
// RULE8 - Error status bit 0 is access violation, bit 1 access timeout, upper bits zero.
// RULE9 - Violation on misaligned descriptor, wrong byte count or unacquired buffer access.
// RULE10 - Timeout on an all-ones descriptor address or a failed automatic release.
// RULE11 - Captured cause bits stay until software reads the error status.
`timescale 1ns/1ps
`include "mtde_cfg.svh"
module mtde_top
    import mtde_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // transmit dma side
    input wire logic dma_running_i,
    input wire logic desc_valid_i,
    input wire logic [31:0] desc_addr_i,
    input wire logic [15:0] desc_len_i,
    input wire logic buf_access_i,
    input wire logic buf_acquired_i,
    input wire logic release_fail_i,
    // interrupts and mode
    output logic tx_dma_error_irq_o,
    output logic buffer_ram_access_error_irq_o,
    output logic irq_o,
    output logic store_forward_select_o,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic rst_meta_reg;
    logic rst_n;
    logic [1:0] errstat_reg;
    logic [31:0] txmode_reg;
    logic [1:0] irqstat_reg;
    logic [1:0] irqmask_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    mtde_wr_state_t wr_state_reg;
    logic wr_fire;
    logic rd_fire;
    logic wr_hit;
    logic rd_hit;
    mtde_sel_t wr_sel;
    mtde_sel_t rd_sel;
    logic any_err;
    logic errstat_read;
    logic irqstat_w1c;
    logic [1:0] w1c_bits;
    logic [31:0] rd_word;

    mtde_chk_if chk ();

    // ==========================================================
    // reset release
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ==========================================================
    // fault checker
    assign chk.running = dma_running_i;
    assign chk.desc_valid = desc_valid_i;
    assign chk.desc_addr = desc_addr_i;
    assign chk.desc_len = desc_len_i;
    assign chk.buf_access = buf_access_i;
    assign chk.buf_acquired = buf_acquired_i;
    assign chk.release_fail = release_fail_i;

    mtde_err_check u_check (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .chk(chk)
    );

    assign any_err = chk.viol || chk.tmo;

    // ==========================================================
    // address decode
    function automatic logic reg_hit(input logic [7:0] addr);
        reg_hit = (addr == `MTDE_OFS_ERRSTAT) || (addr == `MTDE_OFS_TXMODE)
                  || (addr == `MTDE_OFS_IRQSTAT) || (addr == `MTDE_OFS_IRQMASK);
    endfunction : reg_hit

    function automatic mtde_sel_t reg_sel(input logic [7:0] addr);
        case (addr)
            `MTDE_OFS_ERRSTAT: reg_sel = MTDE_SEL_ERRSTAT;
            `MTDE_OFS_TXMODE: reg_sel = MTDE_SEL_TXMODE;
            `MTDE_OFS_IRQSTAT: reg_sel = MTDE_SEL_IRQSTAT;
            default: reg_sel = MTDE_SEL_IRQMASK;
        endcase
    endfunction : reg_sel

    assign wr_fire = aw_held_reg && w_held_reg && (wr_state_reg == MTDE_WR_IDLE);
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign wr_hit = reg_hit(awaddr_reg);
    assign rd_hit = reg_hit(s_axi_araddr);
    assign wr_sel = reg_sel(awaddr_reg);
    assign rd_sel = reg_sel(s_axi_araddr);
    assign errstat_read = rd_fire && rd_hit && (rd_sel == MTDE_SEL_ERRSTAT);
    assign irqstat_w1c = wr_fire && wr_hit && (wr_sel == MTDE_SEL_IRQSTAT) && wstrb_reg[0];
    assign w1c_bits = irqstat_w1c ? wdata_reg[1:0] : 2'h0;

    // ==========================================================
    // error pulses
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_dma_error_irq_o <= 1'b0;
            buffer_ram_access_error_irq_o <= 1'b0;
        end else begin
            tx_dma_error_irq_o <= any_err; // [RULE1] [RULE2]
            buffer_ram_access_error_irq_o <= chk.bram_err; // [RULE5]
        end
    end

    // ==========================================================
    // error cause, held until read
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            errstat_reg <= 2'h0;
        end else begin
            // a new cause beats the read that clears
            errstat_reg <= (errstat_read ? 2'h0 : errstat_reg)
                           | {chk.tmo, chk.viol}; // [RULE8] [RULE11]
        end
    end

    // ==========================================================
    // sticky interrupt status and mask
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            irqstat_reg <= 2'h0;
        end else begin
            irqstat_reg <= (irqstat_reg & ~w1c_bits) | {chk.bram_err, any_err};
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            irqmask_reg <= `MTDE_IRQMASK_RST;
            txmode_reg <= `MTDE_TXMODE_RST;
        end else if (wr_fire && wr_hit) begin
            if (wr_sel == MTDE_SEL_IRQMASK && wstrb_reg[0]) begin
                irqmask_reg <= wdata_reg[1:0];
            end
            if (wr_sel == MTDE_SEL_TXMODE) begin
                for (int b = 0; b < 4; b++) begin
                    if (wstrb_reg[b]) begin
                        txmode_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
                    end
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_o <= 1'b0;
            store_forward_select_o <= 1'b1;
        end else begin
            irq_o <= |(((irqstat_reg & ~w1c_bits) | {chk.bram_err, any_err}) & irqmask_reg);
            store_forward_select_o <= txmode_reg[`MTDE_SF_BIT]; // [RULE6]
        end
    end

    // ==========================================================
    // axi write channel
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready)
                             && (wr_state_reg == MTDE_WR_IDLE);
            s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready)
                            && (wr_state_reg == MTDE_WR_IDLE);
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            wr_state_reg <= MTDE_WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MTDE_RESP_OKAY;
        end else begin
            case (wr_state_reg)
                MTDE_WR_IDLE: begin
                    if (wr_fire) begin
                        wr_state_reg <= MTDE_WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_hit ? `MTDE_RESP_OKAY : `MTDE_RESP_SLVERR;
                    end
                end
                MTDE_WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_reg <= MTDE_WR_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wr_state_reg <= MTDE_WR_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // axi read channel
    always_comb begin
        rd_word = 32'h0000_0000;
        case (rd_sel)
            MTDE_SEL_ERRSTAT: rd_word[1:0] = errstat_reg | {chk.tmo, chk.viol}; // [RULE8]
            MTDE_SEL_TXMODE: rd_word = txmode_reg;
            MTDE_SEL_IRQSTAT: rd_word[1:0] = irqstat_reg;
            MTDE_SEL_IRQMASK: rd_word[1:0] = irqmask_reg;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MTDE_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_fire;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_hit ? rd_word : 32'h0000_0000;
                s_axi_rresp <= rd_hit ? `MTDE_RESP_OKAY : `MTDE_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // checks
    sequence err_cause_s;
        chk.viol || chk.tmo;
    endsequence

    sequence one_pulse_s;
        tx_dma_error_irq_o ##1 !tx_dma_error_irq_o;
    endsequence

    err_pulse_a: assert property (@(posedge clock_i) disable iff (!rst_n) // [RULE1]
        err_cause_s |=> tx_dma_error_irq_o)
        else $error("transmit error pulse missing");
    pulse_width_a: assert property (@(posedge clock_i) disable iff (!rst_n) // [RULE2]
        err_cause_s ##1 !any_err |-> one_pulse_s)
        else $error("transmit error pulse too long");
    no_spurious_a: assert property (@(posedge clock_i) disable iff (!rst_n) // [RULE2]
        tx_dma_error_irq_o |-> $past(any_err))
        else $error("transmit error pulse without cause");
    bram_pulse_a: assert property (@(posedge clock_i) disable iff (!rst_n) // [RULE5]
        dma_running_i && buf_access_i && !buf_acquired_i
        |-> ##2 buffer_ram_access_error_irq_o ##0 tx_dma_error_irq_o)
        else $error("unacquired access not signalled");
    status_upper_a: assert property (@(posedge clock_i) disable iff (!rst_n) // [RULE8]
        s_axi_rvalid && $past(errstat_read) |-> s_axi_rdata[31:2] == 30'h0)
        else $error("error status upper bits not zero");
    cause_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n) // [RULE11]
        errstat_reg[0] && !errstat_read |=> errstat_reg[0])
        else $error("violation cause lost before read");
    timeout_map_a: assert property (@(posedge clock_i) disable iff (!rst_n) // [RULE10]
        dma_running_i && release_fail_i |-> ##2 errstat_reg[1])
        else $error("release failure not seen as timeout");
    len_check_a: assert property (@(posedge clock_i) disable iff (!rst_n) // [RULE7]
        dma_running_i && desc_valid_i && desc_len_i > `MTDE_MAX_FRAME
        && desc_addr_i != `MTDE_END_ADDR |=> chk.viol ##1 tx_dma_error_irq_o)
        else $error("oversized frame not flagged");
    rd_answer_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        rd_fire |=> s_axi_rvalid)
        else $error("read not answered");
endmodule : mtde_top

// ---- mtde_cfg.svh ----
// Purpose: constants for the transmit DMA error signalling block
// Assumes: 32-bit AXI4-Lite register bus, one clock
// Notes: offsets are byte addresses of aligned words
`ifndef MTDE_CFG_SVH
`define MTDE_CFG_SVH

// ==========================================================
// register offsets
`define MTDE_OFS_ERRSTAT 8'h00
`define MTDE_OFS_TXMODE 8'h04
`define MTDE_OFS_IRQSTAT 8'h08
`define MTDE_OFS_IRQMASK 8'h0C

// ==========================================================
// field positions
`define MTDE_ERR_VIOL_BIT 0
`define MTDE_ERR_TMO_BIT 1
`define MTDE_SF_BIT 29
`define MTDE_IRQ_TXERR_BIT 0
`define MTDE_IRQ_BRAM_BIT 1

// ==========================================================
// reset values
`define MTDE_TXMODE_RST 32'h2000_0000
`define MTDE_IRQMASK_RST 2'h0

// ==========================================================
// checks and bus answers
`define MTDE_MAX_FRAME 16'h05EE
`define MTDE_END_ADDR 32'hFFFF_FFFF
`define MTDE_ALIGN_MASK 32'h0000_0007
`define MTDE_RESP_OKAY 2'h0
`define MTDE_RESP_SLVERR 2'h2

`endif

// ---- mtde_pkg.sv ----
// Purpose: shared types of the transmit DMA error signalling block
// Assumes: constants come from mtde_cfg.svh
// Notes: none
package mtde_pkg;

    typedef enum logic [1:0] {
        MTDE_SEL_ERRSTAT,
        MTDE_SEL_TXMODE,
        MTDE_SEL_IRQSTAT,
        MTDE_SEL_IRQMASK
    } mtde_sel_t;

    typedef enum logic {
        MTDE_WR_IDLE,
        MTDE_WR_RESP
    } mtde_wr_state_t;

endpackage : mtde_pkg

// ---- mtde_chk_if.sv ----
// Purpose: carries descriptor checks and their error pulses
// Assumes: one clock domain
// Notes: results are one-cycle pulses
`timescale 1ns/1ps
interface mtde_chk_if;
    logic running;
    logic desc_valid;
    logic [31:0] desc_addr;
    logic [15:0] desc_len;
    logic buf_access;
    logic buf_acquired;
    logic release_fail;
    logic viol;
    logic tmo;
    logic bram_err;

    modport classify (
        input running, desc_valid, desc_addr, desc_len,
        input buf_access, buf_acquired, release_fail,
        output viol, tmo, bram_err
    );
    modport owner (
        output running, desc_valid, desc_addr, desc_len,
        output buf_access, buf_acquired, release_fail,
        input viol, tmo, bram_err
    );
endinterface : mtde_chk_if

// ---- mtde_err_check.sv ----
// Purpose: classifies descriptor and buffer faults into error pulses
// Assumes: inputs synchronous, reset already synchronised
// Notes: every result is registered, one cycle after its cause
`timescale 1ns/1ps
`include "mtde_cfg.svh"
module mtde_err_check (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // checks
    mtde_chk_if.classify chk
);
    logic bad_len;
    logic misaligned;
    logic end_addr;
    logic unacq;

    // ==========================================================
    // fault decode
    assign end_addr = chk.desc_addr == `MTDE_END_ADDR;
    assign misaligned = (chk.desc_addr & `MTDE_ALIGN_MASK) != 32'h0000_0000;
    assign bad_len = (chk.desc_len == 16'h0000) || (chk.desc_len > `MTDE_MAX_FRAME); // [RULE7]
    assign unacq = chk.buf_access && !chk.buf_acquired;

    // ==========================================================
    // pulses, viol and tmo only while the transmit DMA runs, bram_err whether it runs or not
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chk.viol <= 1'b0;
            chk.tmo <= 1'b0;
        end else begin
            // all-ones end value counts as timeout, not misalignment
            chk.viol <= chk.running && ((chk.desc_valid && !end_addr
                        && (misaligned || bad_len)) || unacq); // [RULE9]
            chk.tmo <= chk.running && ((chk.desc_valid && end_addr)
                       || chk.release_fail); // [RULE10]
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chk.bram_err <= 1'b0;
        end else begin
            chk.bram_err <= unacq; // [RULE5]
        end
    end

    tmo_end_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        chk.running && chk.desc_valid && end_addr |=> chk.tmo && !chk.viol) // [RULE10]
        else $error("end address did not give a timeout");
    viol_align_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        chk.running && chk.desc_valid && !end_addr && misaligned |=> chk.viol) // [RULE9]
        else $error("misaligned descriptor not flagged");
endmodule : mtde_err_check

// ---- mtde_dma_model.sv ----
// Purpose: far-side transmit DMA activity driving the error block
// Assumes: one clock, one event at a time, launched after a rising edge
// Notes: released address and length show the inverted last value
`timescale 1ns/1ps
module mtde_dma_model (
    // clock
    input wire logic clock_i,
    // dma activity
    output logic dma_running_o,
    output logic desc_valid_o,
    output logic [31:0] desc_addr_o,
    output logic [15:0] desc_len_o,
    output logic buf_access_o,
    output logic buf_acquired_o,
    output logic release_fail_o
);
    // ==========================================================
    // idle levels
    initial begin
        dma_running_o = 1'b0;
        desc_valid_o = 1'b0;
        desc_addr_o = 32'h0000_0000;
        desc_len_o = 16'h0000;
        buf_access_o = 1'b0;
        buf_acquired_o = 1'b1;
        release_fail_o = 1'b0;
    end

    // ==========================================================
    // one event cycle: kind 0 descriptor, 1 buffer access, 2 release fail
    task automatic send_event(input int kind, input logic run, input logic [31:0] addr,
        input logic [15:0] len, input logic acq);
        @(posedge clock_i);
        dma_running_o <= run;
        desc_valid_o <= (kind == 0);
        buf_access_o <= (kind == 1);
        release_fail_o <= (kind == 2);
        desc_addr_o <= addr;
        desc_len_o <= len;
        buf_acquired_o <= acq;
        @(posedge clock_i);
        desc_valid_o <= 1'b0;
        buf_access_o <= 1'b0;
        release_fail_o <= 1'b0;
        desc_addr_o <= ~addr;
        desc_len_o <= ~len;
    endtask : send_event
endmodule : mtde_dma_model

// ---- mac_tx_dma_error_signalling_tb.sv ----
// Purpose: self-checking bench for the transmit DMA error block
// Assumes: 250 MHz clock, AXI4-Lite master in the bench
// Notes: expected pulses and status come from the bench's own model
`timescale 1ns/1ps
`include "mtde_cfg.svh"
module mac_tx_dma_error_signalling_tb
    import mtde_pkg::*;
;
    // ==========================================================
    // signals
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic run, dv, ba, bq, rf, tx_o, br_o, irq_o, sf_o;
    logic [31:0] da;
    logic [15:0] dl;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, exp_irq;
    logic [31:0] s_axi_rdata, rd, seed = 32'hE74B59BC;
    int mismatches = 0;
    int checked = 0;

    always #2 clock_i = ~clock_i;

    mtde_dma_model mtde_dma_model_i (.clock_i(clock_i), .dma_running_o(run),
        .desc_valid_o(dv), .desc_addr_o(da), .desc_len_o(dl), .buf_access_o(ba),
        .buf_acquired_o(bq), .release_fail_o(rf));

    mtde_top mtde_top_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .dma_running_i(run),
        .desc_valid_i(dv), .desc_addr_i(da), .desc_len_i(dl), .buf_access_i(ba),
        .buf_acquired_i(bq), .release_fail_i(rf), .tx_dma_error_irq_o(tx_o),
        .buffer_ram_access_error_irq_o(br_o), .irq_o(irq_o), .store_forward_select_o(sf_o),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    // ==========================================================
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clock_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock_i);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 50) begin
            chk("write handshake", 32'h0000_0001, 32'h0000_0000);
            end_sim();
        end
        s_axi_bready <= 1'b0;
        chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clock_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock_i);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 50) begin
            chk("read handshake", 32'h0000_0001, 32'h0000_0000);
            end_sim();
        end
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        chk("read response", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : axi_read

    // one event, pulse shape over three cycles, then the captured cause
    task automatic ev(input int k, input logic r, input logic [31:0] a, input logic [15:0] l,
        input logic q);
        logic viol, tmo, bram;
        logic [2:0] txh, brh;
        logic [31:0] v;
        tmo = r && ((k == 0 && a == `MTDE_END_ADDR) || k == 2);
        viol = r && ((k == 1 && !q) || (k == 0 && !tmo &&
            ((a & `MTDE_ALIGN_MASK) != 32'h0 || l == 16'h0 || l > `MTDE_MAX_FRAME)));
        bram = (k == 1) && !q;
        exp_irq = exp_irq | {bram, viol | tmo};
        mtde_dma_model_i.send_event(k, r, a, l, q);
        for (int i = 0; i < 3; i++) begin
            @(posedge clock_i);
            #1;
            txh[i] = tx_o;
            brh[i] = br_o;
        end
        chk("tx error pulse", {29'h0, 2'b00, viol | tmo}, {29'h0, txh});
        chk("bram error pulse", {29'h0, 2'b00, bram}, {29'h0, brh});
        repeat (4) @(posedge clock_i);
        axi_read(`MTDE_OFS_ERRSTAT, v, `MTDE_RESP_OKAY);
        chk("error status", {30'h0, tmo, viol}, v);
    endtask : ev

    // ==========================================================
    // fixed cases: misaligned, corrected retransmit, counts, end value, buffers
    int ck[12] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 2, 2};
    logic cr[12] = '{1, 1, 1, 1, 1, 1, 0, 1, 1, 0, 1, 0};
    logic cq[12] = '{1, 1, 1, 1, 1, 1, 1, 0, 1, 0, 1, 1};
    logic [31:0] ca[12] = '{32'h0000_1004, 32'h0000_1000, 32'h0000_1000, 32'h0000_1000,
        32'h0000_1000, 32'hFFFF_FFFF, 32'h0000_1004, 32'h0000_1000, 32'h0000_1000,
        32'h0000_1000, 32'h0000_1000, 32'h0000_1000};
    logic [15:0] cl[12] = '{16'h0040, 16'h0040, 16'h0000, 16'h05EE, 16'h05EF, 16'h0040,
        16'h0040, 16'h0040, 16'h0040, 16'h0040, 16'h0040, 16'h0040};

    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] r;
        exp_irq = 2'h0;
        repeat (16) @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        chk("store forward after reset", 32'h1, {31'h0, sf_o});
        axi_read(`MTDE_OFS_TXMODE, rd, `MTDE_RESP_OKAY);
        chk("tx mode reset", `MTDE_TXMODE_RST, rd);
        axi_read(`MTDE_OFS_IRQMASK, rd, `MTDE_RESP_OKAY);
        chk("mask reset", 32'h0, rd);
        axi_read(8'h10, rd, `MTDE_RESP_SLVERR);
        chk("unmapped read data", 32'h0, rd);
        axi_write(8'h10, 32'hFFFF_FFFF, `MTDE_RESP_SLVERR);
        axi_write(`MTDE_OFS_TXMODE, 32'h0, `MTDE_RESP_OKAY);
        repeat (2) @(posedge clock_i);
        chk("store forward cleared", 32'h0, {31'h0, sf_o});
        axi_write(`MTDE_OFS_TXMODE, `MTDE_TXMODE_RST, `MTDE_RESP_OKAY);
        repeat (2) @(posedge clock_i);
        chk("store forward set", 32'h1, {31'h0, sf_o});
        for (int i = 0; i < 12; i++) ev(ck[i], cr[i], ca[i], cl[i], cq[i]);
        for (int i = 0; i < 16; i++) begin
            r = xs();
            ev(r % 3, r[4], xs() & (r[5] ? 32'hFFFF_FFF8 : 32'hFFFF_FFFF), xs() % 2000, r[6]);
        end
        axi_read(`MTDE_OFS_ERRSTAT, rd, `MTDE_RESP_OKAY);
        chk("error status cleared by read", 32'h0, rd);
        axi_read(`MTDE_OFS_IRQSTAT, rd, `MTDE_RESP_OKAY);
        chk("irq status", {30'h0, exp_irq}, rd);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        axi_write(`MTDE_OFS_IRQMASK, 32'h3, `MTDE_RESP_OKAY);
        repeat (2) @(posedge clock_i);
        chk("irq unmasked", 32'h1, {31'h0, irq_o});
        axi_write(`MTDE_OFS_IRQSTAT, 32'h3, `MTDE_RESP_OKAY);
        repeat (2) @(posedge clock_i);
        chk("irq after clear", 32'h0, {31'h0, irq_o});
        exp_irq = 2'h0;
        axi_write(`MTDE_OFS_IRQMASK, 32'h1, `MTDE_RESP_OKAY);
        ev(1, 1'b0, 32'h0000_1000, 16'h0040, 1'b0);
        chk("bram masked", 32'h0, {31'h0, irq_o});
        axi_read(`MTDE_OFS_IRQSTAT, rd, `MTDE_RESP_OKAY);
        chk("bram status", {30'h0, exp_irq}, rd);
        axi_write(`MTDE_OFS_IRQMASK, 32'h2, `MTDE_RESP_OKAY);
        repeat (2) @(posedge clock_i);
        chk("bram unmasked", 32'h1, {31'h0, irq_o});
        axi_write(`MTDE_OFS_IRQSTAT, 32'h2, `MTDE_RESP_OKAY);
        repeat (2) @(posedge clock_i);
        chk("bram cleared", 32'h0, {31'h0, irq_o});
        end_sim();
    end
endmodule : mac_tx_dma_error_signalling_tb
